/* ddrtp_regs.vh */
// Purpose: Offsets, field positions, reset values and counts for the
//          DDR3 PHY timing-parameter block.
// Assumes: Every timing figure is in DRAM clock cycles (mclk).
// Notes:   Definitions only; included by the design files.
//
// Operation
// - Sample leveling result after output delay
// - Hold first strobe for leveling mode delay
// - Space refreshes and refresh-activate by refresh time
// - At most four activates per window
// - Mode update delay code gives 12-17 cycles
// - Mode load spacing is four plus field
// - All timing fields count DRAM clock cycles
// - Reset values match the fastest speed grade
// - Column delay bit selects 4 or 5
// - Read turnaround bits apply only during init
// - Low-power state held for clock-enable width
// - Wait self-refresh exit delay before commands
`ifndef DDRTP_REGS_VH
`define DDRTP_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DDRTP_OFS_TIMING1 4'h0
`define DDRTP_OFS_TIMING2 4'h4
`define DDRTP_OFS_STATUS 4'h8

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define DDRTP_TIMING1_RST 32'h228B_B4D2
`define DDRTP_TIMING1_MASK 32'h3FFF_FFFF
`define DDRTP_TIMING2_RST 32'h1003_6A00

// ----------------------------------------------------------------
// Timing word one fields (msb, lsb)
// ----------------------------------------------------------------
`define DDRTP_WLO_MSB 29
`define DDRTP_WLO_LSB 26
`define DDRTP_WLMRD_MSB 25
`define DDRTP_WLMRD_LSB 20
`define DDRTP_RFC_MSB 19
`define DDRTP_RFC_LSB 11
`define DDRTP_FAW_MSB 10
`define DDRTP_FAW_LSB 5
`define DDRTP_MOD_MSB 4
`define DDRTP_MOD_LSB 2
`define DDRTP_MRD_MSB 1
`define DDRTP_MRD_LSB 0

// ----------------------------------------------------------------
// Timing word two fields
// ----------------------------------------------------------------
`define DDRTP_CCD_BIT 31
`define DDRTP_RTW_BIT 30
`define DDRTP_RTODT_BIT 29
`define DDRTP_CKE_MSB 18
`define DDRTP_CKE_LSB 15
`define DDRTP_XS_MSB 9
`define DDRTP_XS_LSB 0

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define DDRTP_MOD_BASE 10'h00C
`define DDRTP_MOD_MAX 3'h5
`define DDRTP_MRD_BASE 10'h004
`define DDRTP_CCD_BASE 10'h004
`define DDRTP_RTW_BASE 10'h006
`define DDRTP_RTODT_BASE 10'h002

// ----------------------------------------------------------------
// Command codes on the sequencer port
// ----------------------------------------------------------------
`define DDRTP_CMD_NOP 3'h0
`define DDRTP_CMD_REF 3'h1
`define DDRTP_CMD_ACT 3'h2
`define DDRTP_CMD_MRS 3'h3
`define DDRTP_CMD_RD 3'h4
`define DDRTP_CMD_WR 3'h5
`define DDRTP_CMD_LPE 3'h6
`define DDRTP_CMD_SRX 3'h7

`endif

/* ddrtp_cnt.v */
// Purpose: Reloadable spacing counter for one timing parameter.
// Assumes: load and val come from logic on mclk.
// Notes:   free_d is the next-cycle view, so callers can register it.
`timescale 1ns/100ps
`default_nettype none
module ddrtp_cnt #(
    parameter W = 10
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Reload
    input wire load,
    input wire [W-1:0] val,
    // State
    output wire free_d,
    output reg busy_q
);

    reg [W-1:0] cnt_q;
    reg [W-1:0] cnt_d;

    // Next count; a zero figure still costs one cycle
    always @* begin
        if (load) begin
            cnt_d = (val == {W{1'b0}}) ? {W{1'b0}} : val - 1'b1;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_d = cnt_q - 1'b1;
        end else begin
            cnt_d = {W{1'b0}};
        end
    end

    assign free_d = (cnt_d == {W{1'b0}});

    // Count register
    always @(posedge mclk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= ~free_d;
        end
    end

endmodule
`default_nettype wire

/* ddrtp_top.v */
// Purpose: Timing store and command spacing for the PHY command path.
// Assumes: One clock; a sequencer offers commands, PHY issues them.
// Notes:   A command offered while its class is not allowed is dropped.
`timescale 1ns/100ps
`default_nettype none
`include "ddrtp_regs.vh"
module ddrtp_top #(
    parameter CW = 10
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Command request from sequencer
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire init_mode,
    output reg [7:0] cmd_allow_q,
    // Command issued to memory
    output reg cmd_issue_q,
    output reg [2:0] cmd_out_q,
    output reg odt_allow_q,
    output reg low_power_q,
    // Write leveling
    input wire wl_start,
    input wire wl_dq,
    output reg wl_dqs_q,
    output reg wl_done_q,
    output reg wl_result_q
);

    // ----------------------------------------------------------------
    // Registers and decoded fields
    // ----------------------------------------------------------------
    reg [31:0] timing1_q;
    reg [31:0] timing2_q;
    reg [1:0] wl_state_q;
    reg dq_meta_q;
    reg dq_sync_q;
    reg [1:0] faw_ptr_q;

    // Leveling states
    localparam [1:0] WL_IDLE = 2'h0;
    localparam [1:0] WL_MODE = 2'h1;
    localparam [1:0] WL_OUT = 2'h2;

    wire [CW-1:0] wlo_cyc;
    wire [CW-1:0] wlmrd_cyc;
    wire [CW-1:0] rfc_cyc;
    wire [CW-1:0] faw_cyc;
    wire [CW-1:0] mod_cyc;
    wire [CW-1:0] mrd_cyc;
    wire [CW-1:0] ccd_cyc;
    wire [CW-1:0] rtw_cyc;
    wire [CW-1:0] rtodt_cyc;
    wire [CW-1:0] cke_cyc;
    wire [CW-1:0] xs_cyc;

    // Mode update code to cycles; reserved codes clamp to longest
    function [CW-1:0] mod_decode;
        input [2:0] code;
        begin
            if (code > `DDRTP_MOD_MAX) begin
                mod_decode = `DDRTP_MOD_BASE + {7'h00, `DDRTP_MOD_MAX};
            end else begin
                mod_decode = `DDRTP_MOD_BASE + {7'h00, code};
            end
        end
    endfunction

    // Leveling, refresh, window, CKE and exit fields are used as they stand
    assign wlo_cyc = {6'h00, timing1_q[`DDRTP_WLO_MSB:`DDRTP_WLO_LSB]};
    assign wlmrd_cyc = {4'h0,
        timing1_q[`DDRTP_WLMRD_MSB:`DDRTP_WLMRD_LSB]};
    assign rfc_cyc = {1'b0, timing1_q[`DDRTP_RFC_MSB:`DDRTP_RFC_LSB]};
    assign faw_cyc = {4'h0, timing1_q[`DDRTP_FAW_MSB:`DDRTP_FAW_LSB]};
    assign mod_cyc =
        mod_decode(timing1_q[`DDRTP_MOD_MSB:`DDRTP_MOD_LSB]);
    assign mrd_cyc = `DDRTP_MRD_BASE +
        {8'h00, timing1_q[`DDRTP_MRD_MSB:`DDRTP_MRD_LSB]};
    assign ccd_cyc = `DDRTP_CCD_BASE +
        {9'h000, timing2_q[`DDRTP_CCD_BIT]};
    assign rtw_cyc = `DDRTP_RTW_BASE + {9'h000, timing2_q[`DDRTP_RTW_BIT]};
    assign rtodt_cyc = `DDRTP_RTODT_BASE +
        {9'h000, timing2_q[`DDRTP_RTODT_BIT]};
    assign cke_cyc = {6'h00, timing2_q[`DDRTP_CKE_MSB:`DDRTP_CKE_LSB]};
    assign xs_cyc = timing2_q[`DDRTP_XS_MSB:`DDRTP_XS_LSB];

    // ----------------------------------------------------------------
    // Register write and read
    // ----------------------------------------------------------------

    // Writes; reserved top bits of word one stay zero
    always @(posedge mclk) begin
        if (rst) begin
            timing1_q <= `DDRTP_TIMING1_RST;
            timing2_q <= `DDRTP_TIMING2_RST;
        end else if (reg_wr) begin
            if (reg_addr == `DDRTP_OFS_TIMING1) begin
                timing1_q <= reg_wdata & `DDRTP_TIMING1_MASK;
            end
            if (reg_addr == `DDRTP_OFS_TIMING2) begin
                timing2_q <= reg_wdata;
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DDRTP_OFS_TIMING1: reg_rdata <= timing1_q;
                `DDRTP_OFS_TIMING2: reg_rdata <= timing2_q;
                `DDRTP_OFS_STATUS: reg_rdata <= {22'h00_0000,
                    cmd_allow_q, wl_result_q, low_power_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Command acceptance
    // ----------------------------------------------------------------
    wire fire;
    wire is_ref;
    wire is_act;
    wire is_mrs;
    wire is_rd;
    wire is_wr;
    wire is_lpe;
    wire is_srx;
    wire lp_d;

    // Only a command whose class is open goes out
    assign fire = cmd_valid & cmd_allow_q[cmd_code] &
        (cmd_code != `DDRTP_CMD_NOP);
    assign is_ref = fire & (cmd_code == `DDRTP_CMD_REF);
    assign is_act = fire & (cmd_code == `DDRTP_CMD_ACT);
    assign is_mrs = fire & (cmd_code == `DDRTP_CMD_MRS);
    assign is_rd = fire & (cmd_code == `DDRTP_CMD_RD);
    assign is_wr = fire & (cmd_code == `DDRTP_CMD_WR);
    assign is_lpe = fire & (cmd_code == `DDRTP_CMD_LPE);
    assign is_srx = fire & (cmd_code == `DDRTP_CMD_SRX);
    assign lp_d = is_lpe | (low_power_q & ~is_srx);

    // ----------------------------------------------------------------
    // Spacing counters
    // ----------------------------------------------------------------
    wire rfc_free;
    wire mod_free;
    wire mrd_free;
    wire ccdr_free;
    wire ccdw_free;
    wire rtw_free;
    wire rtodt_free;
    wire cke_free;
    wire xs_free;
    wire [3:0] faw_free;

    ddrtp_cnt #(.W(CW)) u_rfc (.mclk(mclk), .rst(rst),
        .load(is_ref), .val(rfc_cyc),
        .free_d(rfc_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_mod (.mclk(mclk), .rst(rst),
        .load(is_mrs), .val(mod_cyc),
        .free_d(mod_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_mrd (.mclk(mclk), .rst(rst),
        .load(is_mrs), .val(mrd_cyc),
        .free_d(mrd_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_ccdr (.mclk(mclk), .rst(rst),
        .load(is_rd), .val(ccd_cyc),
        .free_d(ccdr_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_ccdw (.mclk(mclk), .rst(rst),
        .load(is_wr), .val(ccd_cyc),
        .free_d(ccdw_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_rtw (.mclk(mclk), .rst(rst),
        .load(is_rd & init_mode), .val(rtw_cyc),
        .free_d(rtw_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_rtodt (.mclk(mclk), .rst(rst),
        .load(is_rd & init_mode), .val(rtodt_cyc),
        .free_d(rtodt_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_cke (.mclk(mclk), .rst(rst),
        .load(is_lpe), .val(cke_cyc),
        .free_d(cke_free), .busy_q());
    ddrtp_cnt #(.W(CW)) u_xs (.mclk(mclk), .rst(rst),
        .load(is_srx), .val(xs_cyc),
        .free_d(xs_free), .busy_q());

    // Four window slots; each activate claims the slot in turn
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_faw
            ddrtp_cnt #(.W(CW)) u_faw (.mclk(mclk), .rst(rst),
                .load(is_act & (faw_ptr_q == gi)), .val(faw_cyc),
                .free_d(faw_free[gi]), .busy_q());
        end
    endgenerate

    // Round-robin slot pointer; the oldest activate is always next
    always @(posedge mclk) begin
        if (rst) begin
            faw_ptr_q <= 2'h0;
        end else if (is_act) begin
            faw_ptr_q <= faw_ptr_q + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Allow flags, registered from next-cycle counter view
    // ----------------------------------------------------------------
    wire gate_all;
    reg [7:0] allow_d;

    // Mode load and self-refresh exit block every command
    assign gate_all = mrd_free & xs_free & ~lp_d;

    always @* begin
        allow_d = 8'h00;
        allow_d[`DDRTP_CMD_REF] = gate_all & rfc_free & mod_free;
        allow_d[`DDRTP_CMD_ACT] = gate_all & rfc_free & mod_free &
            faw_free[faw_ptr_q + {1'b0, is_act}];
        allow_d[`DDRTP_CMD_MRS] = gate_all;
        allow_d[`DDRTP_CMD_RD] = gate_all & mod_free & ccdr_free;
        allow_d[`DDRTP_CMD_WR] = gate_all & mod_free & ccdw_free &
            (rtw_free | ~init_mode);
        allow_d[`DDRTP_CMD_LPE] = gate_all & mod_free;
        allow_d[`DDRTP_CMD_SRX] = lp_d & cke_free & mrd_free;
    end

    // Issue path toward the memory pins
    always @(posedge mclk) begin
        if (rst) begin
            cmd_allow_q <= 8'h00;
            cmd_issue_q <= 1'b0;
            cmd_out_q <= `DDRTP_CMD_NOP;
            odt_allow_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            cmd_allow_q <= allow_d;
            cmd_issue_q <= fire;
            cmd_out_q <= fire ? cmd_code : `DDRTP_CMD_NOP;
            odt_allow_q <= rtodt_free | ~init_mode;
            low_power_q <= lp_d;
        end
    end

    // ----------------------------------------------------------------
    // Write leveling
    // ----------------------------------------------------------------
    wire wl_free;
    wire wl_load;
    wire [CW-1:0] wl_val;
    reg wl_free_q;

    // Mode delay first, then output delay with strobe high
    assign wl_load = (wl_state_q == WL_IDLE) ? wl_start :
        ((wl_state_q == WL_MODE) & wl_free_q);
    assign wl_val = (wl_state_q == WL_IDLE) ? wlmrd_cyc : wlo_cyc;

    ddrtp_cnt #(.W(CW)) u_wl (.mclk(mclk), .rst(rst),
        .load(wl_load), .val(wl_val),
        .free_d(wl_free), .busy_q());

    // Data pin crosses in through two flops before use
    always @(posedge mclk) begin
        if (rst) begin
            dq_meta_q <= 1'b0;
            dq_sync_q <= 1'b0;
        end else begin
            dq_meta_q <= wl_dq;
            dq_sync_q <= dq_meta_q;
        end
    end

    // Leveling sequencer
    always @(posedge mclk) begin
        if (rst) begin
            wl_state_q <= WL_IDLE;
            wl_free_q <= 1'b0;
            wl_dqs_q <= 1'b0;
            wl_done_q <= 1'b0;
            wl_result_q <= 1'b0;
        end else begin
            wl_free_q <= wl_free & ~wl_load;
            wl_done_q <= 1'b0;
            case (wl_state_q)
                WL_IDLE: begin
                    if (wl_start) begin
                        wl_state_q <= WL_MODE;
                    end
                end
                WL_MODE: begin
                    if (wl_free_q) begin
                        wl_dqs_q <= 1'b1;
                        wl_state_q <= WL_OUT;
                    end
                end
                WL_OUT: begin
                    if (wl_free_q) begin
                        wl_result_q <= dq_sync_q;
                        wl_done_q <= 1'b1;
                        wl_dqs_q <= 1'b0;
                        wl_state_q <= WL_IDLE;
                    end
                end
                default: begin
                    wl_state_q <= WL_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* ddrtp_monitor.sv */
// Purpose: Port-level checks on the timing-parameter block.
// Assumes: Shadow timing word follows register-port writes.
// Notes:   Spacing is the age between issue pulses.
`timescale 1ns/100ps
`default_nettype none
`include "ddrtp_regs.vh"
module ddrtp_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Issued commands
    input wire logic cmd_issue_q,
    input wire logic [2:0] cmd_out_q,
    input wire logic low_power_q,
    // Write leveling
    input wire logic wl_start,
    input wire logic wl_dqs_q,
    input wire logic wl_done_q
);
    logic [31:0] t1_q;
    logic ccd_q;
    logic [11:0] ref_q, mrs_q, rd_q, wl_q, dqs_q;
    wire [11:0] mod_n = (t1_q[4:2] > 3'h5) ? 12'h011 : 12'h00C + t1_q[4:2];
    wire is_ref = cmd_issue_q && cmd_out_q == `DDRTP_CMD_REF;
    wire is_mrs = cmd_issue_q && cmd_out_q == `DDRTP_CMD_MRS;
    wire is_rd = cmd_issue_q && cmd_out_q == `DDRTP_CMD_RD;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Saturating age, so a long-idle class never looks recent
    function automatic logic [11:0] age(input logic [11:0] a, input logic hit);
        age = hit ? 12'h001 : ((a == 12'hFFF) ? a : a + 12'h001);
    endfunction

    // Shadow of timing words and ages since each cause
    always @(posedge mclk) begin
        if (rst) begin
            t1_q <= 32'h228B_B4D2;
            ccd_q <= 1'b0;
            ref_q <= 12'hFFF;
            mrs_q <= 12'hFFF;
            rd_q <= 12'hFFF;
            wl_q <= 12'hFFF;
            dqs_q <= 12'h000;
        end else begin
            if (reg_wr && reg_addr == `DDRTP_OFS_TIMING1)
                t1_q <= reg_wdata & 32'h3FFF_FFFF;
            if (reg_wr && reg_addr == `DDRTP_OFS_TIMING2)
                ccd_q <= reg_wdata[31];
            ref_q <= age(ref_q, is_ref);
            mrs_q <= age(mrs_q, is_mrs);
            rd_q <= age(rd_q, is_rd);
            wl_q <= age(wl_q, wl_start);
            dqs_q <= wl_dqs_q ? dqs_q + 12'h001 : 12'h000;
        end
    end

    ref_spacing_a: assert property (is_ref || (cmd_issue_q &&
        cmd_out_q == `DDRTP_CMD_ACT) |-> ref_q >= t1_q[19:11])
        else $error("refresh spacing too short");
    mode_load_a: assert property (cmd_issue_q |->
        mrs_q >= 12'h004 + t1_q[1:0])
        else $error("mode load spacing too short");
    mode_update_a: assert property (cmd_issue_q && !is_mrs |->
        mrs_q >= mod_n)
        else $error("mode update delay too short");
    column_gap_a: assert property (is_rd |-> rd_q >= 12'h004 + ccd_q)
        else $error("read to read spacing too short");
    level_mode_a: assert property ($rose(wl_dqs_q) |->
        wl_q >= t1_q[25:20])
        else $error("leveling strobe too early");
    level_out_a: assert property ($rose(wl_done_q) |->
        dqs_q >= t1_q[29:26])
        else $error("leveling sample too early");
    low_power_a: assert property ($past(low_power_q) && cmd_issue_q |->
        cmd_out_q == `DDRTP_CMD_SRX)
        else $error("command issued in low power");
    rsvd_zero_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == 4'h0 |-> reg_rdata[31:30] == 2'b00)
        else $error("reserved bits read nonzero");

    cover property (is_mrs ##[1:30] is_mrs);
    cover property (cmd_issue_q && cmd_out_q == `DDRTP_CMD_SRX);
    cover property ($rose(wl_done_q));
endmodule
`default_nettype wire

/* ddrtp_sdram_model.sv */
// Purpose: Memory-side answer to the leveling strobe.
// Assumes: Memory echoes strobe on dq after its own delay.
// Notes:   Slow mode needs 20 strobe cycles, more than the PHY window lasts.
`timescale 1ns/100ps
`default_nettype none
module ddrtp_sdram_model (
    // Clock
    input wire logic mclk,
    // Leveling strobe and answer
    input wire logic wl_dqs,
    input wire logic slow,
    output logic wl_dq
);
    int n = 0;
    // Dq drops with strobe, so no stale answer survives a cycle
    always @(posedge mclk) begin
        n <= wl_dqs ? n + 1 : 0;
        wl_dq <= wl_dqs && (n >= (slow ? 20 : 1));
    end
endmodule
`default_nettype wire

/* ddrtp_top_bench.sv */
// Purpose: Register and command-spacing tests for the timing block.
// Assumes: Spacing may exceed the minimum by up to two cycles.
// Notes:   Offers last one cycle, so a blocked code never queues.
`timescale 1ns/100ps
`default_nettype none
`include "ddrtp_regs.vh"
module ddrtp_top_bench;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic cmd_valid = 1'b0, init_mode = 1'b0, wl_start = 1'b0, slow = 1'b0;
    logic [2:0] cmd_code = 3'h0, cmd_out_q;
    logic [7:0] cmd_allow_q;
    logic cmd_issue_q, odt_allow_q, low_power_q;
    logic wl_dq, wl_dqs_q, wl_done_q, wl_result_q;
    int err_total = 0, samples_checked = 0, d, s;

    ddrtp_top ddrtp_top_inst (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cmd_valid, .cmd_code, .init_mode, .cmd_allow_q,
        .cmd_issue_q, .cmd_out_q, .odt_allow_q, .low_power_q, .wl_start,
        .wl_dq, .wl_dqs_q, .wl_done_q, .wl_result_q);
    ddrtp_sdram_model ddrtp_sdram_model_inst (.mclk, .wl_dqs(wl_dqs_q),
        .slow, .wl_dq);

    always #12.5 mclk = ~mclk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        check(reg_rdata, e);
    endtask
    // Offer once allowed; d ends as spacing from the previous take
    task issue(input logic [2:0] c);
        d = 2;
        while (cmd_allow_q[c] !== 1'b1 && d < 4000) begin
            @(posedge mclk);
            d++;
        end
        cmd_code <= c;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(posedge mclk);
        check({cmd_issue_q, cmd_out_q}, {1'b1, c});
    endtask
    task gap(input int n);
        check(d >= n && d <= n + 2, 1);
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(4'h0, 32'h228B_B4D2);
        rd(4'h4, 32'h1003_6A00);
        rd(4'h8, 32'h0000_01F8);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, 32'h0000_0000);
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, 32'h3FFF_FFFF);
        // wlo 6, wlmrd 5, refresh 10, window 20, mode code 0, load 1
        wr(4'h0, 32'h1850_5281);
        issue(`DDRTP_CMD_REF);
        issue(`DDRTP_CMD_REF);
        gap(10);
        issue(`DDRTP_CMD_ACT);
        gap(10);
        s = 0;
        repeat (4) begin
            issue(`DDRTP_CMD_ACT);
            s += d;
        end
        d = s;
        gap(20);
        for (int m = 0; m < 8; m++) begin
            wr(4'h0, 32'h1850_5280 | (m << 2) | (m & 3));
            issue(`DDRTP_CMD_MRS);
            issue(`DDRTP_CMD_MRS);
            gap(4 + m % 4);
            issue(`DDRTP_CMD_WR);
            gap(m > 5 ? 17 : 12 + m);
        end
        for (int b = 0; b < 2; b++) begin
            wr(4'h4, 32'h1003_6A00 | (b << 31) | (b << 30) | (b << 29));
            init_mode <= 1'b1;
            issue(`DDRTP_CMD_RD);
            issue(`DDRTP_CMD_RD);
            check(odt_allow_q, 0);
            gap(4 + b);
            issue(`DDRTP_CMD_WR);
            gap(6 + b);
            check(odt_allow_q, 1);
            init_mode <= 1'b0;
            issue(`DDRTP_CMD_RD);
            check(odt_allow_q, 1);
            issue(`DDRTP_CMD_WR);
            gap(2);
        end
        issue(`DDRTP_CMD_LPE);
        check(low_power_q, 1);
        check(cmd_allow_q[`DDRTP_CMD_REF], 0);
        issue(`DDRTP_CMD_SRX);
        gap(6);
        issue(`DDRTP_CMD_REF);
        gap(512);
        // Prompt memory answer is seen; slow one misses the window
        // Output delay 12, mode delay 5
        wr(4'h0, 32'h3050_5281);
        for (int k = 0; k < 2; k++) begin
            slow <= k[0];
            wl_start <= 1'b1;
            @(posedge mclk);
            wl_start <= 1'b0;
            s = 0;
            while (wl_dqs_q !== 1'b1 && s < 200) begin
                @(posedge mclk);
                s++;
            end
            check(s >= 5 && s <= 9, 1);
            s = 0;
            while (wl_done_q !== 1'b1 && s < 200) begin
                @(posedge mclk);
                s++;
            end
            check(s >= 12 && s <= 16, 1);
            check(wl_result_q, k == 0);
        end
        end_sim;
    end

    // Watchdog, far beyond the fewer than one thousand cycles the tests need
    initial begin
        #500000;
        err_total++;
        end_sim;
    end
endmodule

bind ddrtp_top ddrtp_monitor ddrtp_monitor_inst (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_issue_q, .cmd_out_q,
    .low_power_q, .wl_start, .wl_dqs_q, .wl_done_q);
`default_nettype wire
